//--- logic/tprs_pkg.sv
// tprs_pkg: constants for the timer pin route select block
package tprs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_WAVE = 12;

  // register map
  localparam logic [ADDR_W-1:0] U0_ROUTE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] U1_ROUTE_ADDR = 8'h04;

  // values after reset and writable bits
  localparam logic [DATA_W-1:0] U0_ROUTE_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] U1_ROUTE_RST  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] U0_ROUTE_MASK = 32'h0000_0FFF;
  localparam logic [DATA_W-1:0] U1_ROUTE_MASK = 32'hFFFF_1FFF;

  // unit 1 field positions
  localparam int CAP13_LSB     = 29;
  localparam int CAP12_LSB     = 26;
  localparam int CAP11_LSB     = 23;
  localparam int CAP10_LSB     = 20;
  localparam int CNT_CLK_LSB   = 18;
  localparam int TRIP_IN_LSB   = 16;
  localparam int RSV_LSB       = 13;
  localparam int TRIP_MODE_BIT = 12;
  localparam int WAVE_SEL_W    = 2;
  localparam int CAP_SEL_W     = 3;

  // wave route codes
  localparam logic [1:0] ROUTE_OFF  = 2'h0;
  localparam logic [1:0] ROUTE_OPT0 = 2'h1;
  localparam logic [1:0] ROUTE_OPT1 = 2'h2;

  // capture source codes
  localparam logic [2:0] CAP_PIN0   = 3'h0;
  localparam logic [2:0] CAP_PIN0_B = 3'h1;
  localparam logic [2:0] CAP_PIN1   = 3'h2;
  localparam logic [2:0] CAP_SER_LO = 3'h4;
  localparam logic [2:0] CAP_SER_HI = 3'h5;

  // serial channels whose sync detect feeds captures 13 and 12
  localparam int CAP13_SER_LO = 3;
  localparam int CAP13_SER_HI = 7;
  localparam int CAP12_SER_LO = 2;
  localparam int CAP12_SER_HI = 6;

  // first wave channel index belonging to unit 1
  localparam int U1_WAVE_BASE = 6;

endpackage

//--- logic/tprs_wave_route.sv
// tprs_wave_route: one waveform channel steered onto two pad options
`timescale 1ns/1ps
module tprs_wave_route (
  // selector and source
  input  wire logic [1:0] i_sel,
  input  wire logic       i_data,
  // pad options, enables active low
  output logic            o_pad0,
  output logic            o_pad1,
  output logic            o_pad0_oe_n,
  output logic            o_pad1_oe_n
);
  import tprs_pkg::*;

  wire use0 = (i_sel == ROUTE_OPT0);
  wire use1 = (i_sel == ROUTE_OPT1);

  // prohibited 11 drives nothing, same as 00
  assign o_pad0      = use0 & i_data;
  assign o_pad1      = use1 & i_data;
  assign o_pad0_oe_n = ~use0;
  assign o_pad1_oe_n = ~use1;

endmodule // tprs_wave_route

//--- logic/tprs_top.sv
// tprs_top: route registers, wave pad steering and capture input selection
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
module tprs_top (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic                          i_rst_deep_stby,
  // register port
  input  wire logic [tprs_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [tprs_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [tprs_pkg::DATA_W-1:0]   o_rdata,
  // timer side
  input  wire logic [tprs_pkg::NUM_WAVE-1:0] i_wave,
  input  wire logic                          i_unit1_trip_flag,
  input  wire logic [5:0]                    i_gpio_out,
  input  wire logic [7:0]                    i_serial_sync,
  // capture pins, asynchronous
  input  wire logic [1:0]                    i_cap_pin0,
  input  wire logic [1:0]                    i_cap_pin1,
  // pads
  output logic      [tprs_pkg::NUM_WAVE-1:0] o_pad0,
  output logic      [tprs_pkg::NUM_WAVE-1:0] o_pad1,
  output logic      [tprs_pkg::NUM_WAVE-1:0] o_pad0_oe_n,
  output logic      [tprs_pkg::NUM_WAVE-1:0] o_pad1_oe_n,
  // capture inputs
  output logic                               o_capture13,
  output logic                               o_capture12
);
  import tprs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] unit0_timer_pin_route;
  logic [DATA_W-1:0] unit1_timer_pin_route;
  logic [DATA_W-1:0] next_unit0;
  logic [DATA_W-1:0] next_unit1;

  wire u0_hit = (i_addr == U0_ROUTE_ADDR);
  wire u1_hit = (i_addr == U1_ROUTE_ADDR);
  wire u0_wr  = i_wr & u0_hit;
  wire u1_wr  = i_wr & u1_hit;

  // deep standby reset leaves unit 0 alone
  assign next_unit0 = i_rst ? (i_rst_deep_stby ? unit0_timer_pin_route : U0_ROUTE_RST)
                    : u0_wr ? (i_wdata & U0_ROUTE_MASK)
                    : unit0_timer_pin_route;
  // reserved bits masked so they always read back zero
  assign next_unit1 = i_rst ? U1_ROUTE_RST
                    : u1_wr ? (i_wdata & U1_ROUTE_MASK)
                    : unit1_timer_pin_route;

  always_ff @(posedge i_clk) begin
    unit0_timer_pin_route <= next_unit0;
    unit1_timer_pin_route <= next_unit1;
  end

  // read data stands only in the cycle after the strobe
  wire [DATA_W-1:0] rd_mux = u0_hit ? unit0_timer_pin_route
                           : u1_hit ? unit1_timer_pin_route
                           : '0;
  wire [DATA_W-1:0] next_rdata = (i_rd & ~i_rst) ? rd_mux : '0;

  always_ff @(posedge i_clk) begin
    o_rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wave routing

  // built from next register values so a write shows one cycle later
  wire [2*NUM_WAVE-1:0] next_sel = {next_unit1[11:0], next_unit0[11:0]};
  wire trip_take = unit1_timer_pin_route[TRIP_MODE_BIT] & i_unit1_trip_flag;

  logic [NUM_WAVE-1:0] wave_data;
  logic [NUM_WAVE-1:0] next_pad0;
  logic [NUM_WAVE-1:0] next_pad1;
  logic [NUM_WAVE-1:0] next_oe0_n;
  logic [NUM_WAVE-1:0] next_oe1_n;

  genvar k;
  generate
    for (k = 0; k < NUM_WAVE; k = k + 1) begin : g_wave
      if (k >= U1_WAVE_BASE) begin : g_u1
        // trip hands unit 1 pads to general purpose levels
        assign wave_data[k] = trip_take ? i_gpio_out[k-U1_WAVE_BASE] : i_wave[k];
      end else begin : g_u0
        assign wave_data[k] = i_wave[k];
      end
      // indices 0..5: unit 0 channels 0..5; indices 6..11: unit 1 channels 10..15
      tprs_wave_route u_route (
        .i_sel       (next_sel[2*k +: WAVE_SEL_W]),
        .i_data      (wave_data[k]),
        .o_pad0      (next_pad0[k]),
        .o_pad1      (next_pad1[k]),
        .o_pad0_oe_n (next_oe0_n[k]),
        .o_pad1_oe_n (next_oe1_n[k])
      );
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pad0      <= '0;
      o_pad1      <= '0;
      o_pad0_oe_n <= '1;
      o_pad1_oe_n <= '1;
    end else begin
      o_pad0      <= next_pad0;
      o_pad1      <= next_pad1;
      o_pad0_oe_n <= next_oe0_n;
      o_pad1_oe_n <= next_oe1_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture input selection

  logic [3:0] cap_s1;
  logic [3:0] cap_s2;

  always_ff @(posedge i_clk) begin
    cap_s1 <= {i_cap_pin1, i_cap_pin0};
    cap_s2 <= cap_s1;
  end

  wire [2:0] sel13 = next_unit1[CAP13_LSB +: CAP_SEL_W];
  wire [2:0] sel12 = next_unit1[CAP12_LSB +: CAP_SEL_W];

  // prohibited codes feed a quiet low level
  wire next_cap13 = (sel13 == CAP_PIN0 || sel13 == CAP_PIN0_B) ? cap_s2[1]
                  : (sel13 == CAP_PIN1)   ? cap_s2[3]
                  : (sel13 == CAP_SER_LO) ? i_serial_sync[CAP13_SER_LO]
                  : (sel13 == CAP_SER_HI) ? i_serial_sync[CAP13_SER_HI]
                  : 1'b0;
  wire next_cap12 = (sel12 == CAP_PIN0 || sel12 == CAP_PIN0_B) ? cap_s2[0]
                  : (sel12 == CAP_PIN1)   ? cap_s2[2]
                  : (sel12 == CAP_SER_LO) ? i_serial_sync[CAP12_SER_LO]
                  : (sel12 == CAP_SER_HI) ? i_serial_sync[CAP12_SER_HI]
                  : 1'b0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_capture13 <= 1'b0;
      o_capture12 <= 1'b0;
    end else begin
      o_capture13 <= next_cap13;
      o_capture12 <= next_cap12;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_RESET_OFF: assert property (@(posedge i_clk)
    ($past(i_rst) && !$past(i_rst_deep_stby)) |-> (unit0_timer_pin_route[11:0] == 12'h000))
    else $error("wave selectors not cleared by reset");

  AST_DEEP_KEEP: assert property (@(posedge i_clk)
    ($past(i_rst) && $past(i_rst_deep_stby)) |-> (unit0_timer_pin_route == $past(unit0_timer_pin_route)))
    else $error("unit 0 route lost in deep standby reset");

  AST_CAP_RESET: assert property (@(posedge i_clk)
    $past(i_rst) |-> (unit1_timer_pin_route[31:26] == 6'h00))
    else $error("capture selectors not zero after reset");

  AST_READBACK: assert property (@(posedge i_clk) disable iff (i_rst)
    (u0_wr && !i_rd) ##1 (i_rd && u0_hit && !i_wr && !i_rst)
      |=> (o_rdata == ($past(i_wdata, 2) & U0_ROUTE_MASK)))
    else $error("unit 0 read back differs from write");

  AST_RSV_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd && u1_hit) |-> (o_rdata[15:13] == 3'h0))
    else $error("reserved bits read non-zero");

  AST_CH1_OPT0: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[3:2] == 2'h1)
      |-> (!o_pad0_oe_n[1] && o_pad1_oe_n[1] && o_pad0[1] == $past(i_wave[1])))
    else $error("channel 1 not on pad option 0");

  AST_CH3_OPT1: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[7:6] == 2'h2)
      |-> (o_pad0_oe_n[3] && !o_pad1_oe_n[3] && o_pad1[3] == $past(i_wave[3])))
    else $error("channel 3 not on pad option 1");

  AST_CH5_PROHIB: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit0_timer_pin_route[11:10] == 2'h3) |-> (o_pad0_oe_n[5] && o_pad1_oe_n[5]))
    else $error("channel 5 driven on prohibited code");

  AST_CH0_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst)
    (u0_wr && i_wdata[1:0] == 2'h1) |=> (!o_pad0_oe_n[0] && o_pad1_oe_n[0]))
    else $error("channel 0 route not active one cycle after write");

  AST_CAP13_SER: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[31:29] == 3'h4)
      |-> (o_capture13 == $past(i_serial_sync[3])))
    else $error("capture 13 not fed from serial channel 3");

  AST_CAP12_PIN1: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[28:26] == 3'h2)
      |-> (o_capture12 == $past(cap_s2[2])))
    else $error("capture 12 not fed from pin option 1");

  AST_TRIP_GPIO: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[1:0] == 2'h1
      && $past(unit1_timer_pin_route[TRIP_MODE_BIT]) && $past(i_unit1_trip_flag))
      |-> (o_pad0[6] == $past(i_gpio_out[0])))
    else $error("trip did not hand channel 10 to general purpose");

  AST_TRIP_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[3:2] == 2'h1
      && !$past(unit1_timer_pin_route[TRIP_MODE_BIT]))
      |-> (o_pad0[7] == $past(i_wave[7])))
    else $error("channel 11 left its wave while trip mode is off");

  AST_CH0_OPT1: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[1:0] == 2'h2)
      |-> (o_pad0_oe_n[0] && !o_pad1_oe_n[0] && o_pad1[0] == $past(i_wave[0])))
    else $error("channel 0 not on pad option 1");

  // an unrouted channel must leave both pads quiet, not only undriven
  AST_CH2_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit0_timer_pin_route[5:4] == 2'h0)
      |-> (o_pad0_oe_n[2] && o_pad1_oe_n[2] && !o_pad0[2] && !o_pad1[2]))
    else $error("channel 2 driven while routed off");

  AST_CH2_OPT0: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[5:4] == 2'h1)
      |-> (!o_pad0_oe_n[2] && o_pad1_oe_n[2] && o_pad0[2] == $past(i_wave[2])))
    else $error("channel 2 not on pad option 0");

  AST_CH4_OPT0: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[9:8] == 2'h1)
      |-> (!o_pad0_oe_n[4] && o_pad1_oe_n[4] && o_pad0[4] == $past(i_wave[4])))
    else $error("channel 4 not on pad option 0");

  AST_CH4_PROHIB: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit0_timer_pin_route[9:8] == 2'h3)
      |-> (o_pad0_oe_n[4] && o_pad1_oe_n[4]))
    else $error("channel 4 driven on prohibited code");

  AST_CH5_OPT1: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit0_timer_pin_route[11:10] == 2'h2)
      |-> (o_pad0_oe_n[5] && !o_pad1_oe_n[5] && o_pad1[5] == $past(i_wave[5])))
    else $error("channel 5 not on pad option 1");

  // unit 1 enables follow the selector whether or not the trip is active
  AST_U1_CH15_OPT0: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit1_timer_pin_route[11:10] == 2'h1)
      |-> (!o_pad0_oe_n[11] && o_pad1_oe_n[11]))
    else $error("channel 15 not enabled on pad option 0");

  AST_U1_CH10_OPT1: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit1_timer_pin_route[1:0] == 2'h2)
      |-> (o_pad0_oe_n[6] && !o_pad1_oe_n[6]))
    else $error("channel 10 not enabled on pad option 1");

  AST_U1_PROHIB: assert property (@(posedge i_clk) disable iff (i_rst)
    (unit1_timer_pin_route[5:4] == 2'h3)
      |-> (o_pad0_oe_n[8] && o_pad1_oe_n[8]))
    else $error("channel 12 driven on prohibited code");

  AST_PAD_RESET: assert property (@(posedge i_clk)
    $past(i_rst)
      |-> ((&o_pad0_oe_n) && (&o_pad1_oe_n) && o_pad0 == '0 && o_pad1 == '0))
    else $error("pads driven during reset");

  // read data must not linger past its one cycle
  AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rd)
      |-> (o_rdata == '0))
    else $error("read data present without a read");

  AST_RD_UNIT1: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd && u1_hit && !i_rst)
      |-> (o_rdata == $past(unit1_timer_pin_route)))
    else $error("unit 1 read differs from stored value");

  AST_RD_UNMAPPED: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rd && !u0_hit && !u1_hit)
      |-> (o_rdata == '0))
    else $error("unmapped read returned non-zero");

  AST_CAP13_PIN0: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[31:30] == 2'h0)
      |-> (o_capture13 == $past(cap_s2[1])))
    else $error("capture 13 not fed from pin option 0");

  AST_CAP13_PIN1: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[31:29] == 3'h2)
      |-> (o_capture13 == $past(cap_s2[3])))
    else $error("capture 13 not fed from pin option 1");

  // prohibited codes must never leak a live source into the capture
  AST_CAP13_PROHIB: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && (unit1_timer_pin_route[31:29] == 3'h3
      || unit1_timer_pin_route[31:29] > 3'h5))
      |-> !o_capture13)
    else $error("capture 13 active on prohibited code");

  AST_CAP12_SER_HI: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && unit1_timer_pin_route[28:26] == 3'h5)
      |-> (o_capture12 == $past(i_serial_sync[6])))
    else $error("capture 12 not fed from serial channel 6");

  AST_CAP12_PROHIB: assert property (@(posedge i_clk) disable iff (i_rst)
    (!$past(i_rst) && (unit1_timer_pin_route[28:26] == 3'h3
      || unit1_timer_pin_route[28:26] > 3'h5))
      |-> !o_capture12)
    else $error("capture 12 active on prohibited code");

  AST_CAP_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst)
    (u1_wr && i_wdata[CAP12_LSB +: CAP_SEL_W] == CAP_SER_LO)
      |=> (o_capture12 == $past(i_serial_sync[CAP12_SER_LO])))
    else $error("capture 12 source not switched one cycle after write");

endmodule // tprs_top

//--- tb/tprs_timer_model.sv
// tprs_timer_model: timer, serial sync and capture pin levels facing the route block
`timescale 1ns/1ps
module tprs_timer_model #(
  parameter logic [11:0] WAVE_V = 12'h000,
  parameter logic [7:0]  SYNC_V = 8'h00,
  parameter logic [1:0]  PIN0_V = 2'h0,
  parameter logic [1:0]  PIN1_V = 2'h0
) (
  // clock and trip request from the bench
  input  wire logic        i_clk,
  input  wire logic        i_trip_set,
  input  wire logic [5:0]  i_gpio_set,
  // levels toward the route block
  output logic      [11:0] o_wave,
  output logic             o_trip,
  output logic      [5:0]  o_gpio,
  output logic      [7:0]  o_sync,
  output logic      [1:0]  o_pin0,
  output logic      [1:0]  o_pin1
);
  // timer levels leave flops, as they would from the real units
  always_ff @(posedge i_clk) begin
    o_wave <= WAVE_V;
    o_trip <= i_trip_set;
    o_gpio <= i_gpio_set;
    o_sync <= SYNC_V;
  end
  // fixed pad levels leave the synchroniser and the capture output flop as the only capture latency
  assign o_pin0 = PIN0_V;
  assign o_pin1 = PIN1_V;
endmodule // tprs_timer_model

//--- tb/tb.sv
// tb: register, pad, trip, capture and reset checks of the route block
`timescale 1ns/1ps
module tb;
  import tprs_pkg::*;
  localparam logic [11:0] WAVE_PAT = 12'hA5C;
  localparam logic [7:0]  SYNC_PAT = 8'h84;
  localparam logic [1:0]  PIN0_PAT = 2'h2;
  localparam logic [1:0]  PIN1_PAT = 2'h1;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_rst_deep_stby = 1'b0;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        trip_set = 1'b0;
  logic [5:0]  gpio_set = 6'h2A;
  logic [31:0] o_rdata;
  logic [11:0] wave, pad0, pad1, oe0_n, oe1_n;
  logic [7:0]  sync;
  logic [5:0]  gpio;
  logic [1:0]  pin0, pin1;
  logic        trip, cap13, cap12;
  int          err_count = 0;
  int          num_checks = 0;
  always #4 i_clk = ~i_clk;
  tprs_timer_model #(.WAVE_V(WAVE_PAT), .SYNC_V(SYNC_PAT), .PIN0_V(PIN0_PAT),
    .PIN1_V(PIN1_PAT)) partner (.i_clk(i_clk), .i_trip_set(trip_set),
    .i_gpio_set(gpio_set), .o_wave(wave), .o_trip(trip), .o_gpio(gpio),
    .o_sync(sync), .o_pin0(pin0), .o_pin1(pin1));
  tprs_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_rst_deep_stby(i_rst_deep_stby),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_wave(wave), .i_unit1_trip_flag(trip), .i_gpio_out(gpio), .i_serial_sync(sync),
    .i_cap_pin0(pin0), .i_cap_pin1(pin1), .o_pad0(pad0), .o_pad1(pad1),
    .o_pad0_oe_n(oe0_n), .o_pad1_oe_n(oe1_n), .o_capture13(cap13), .o_capture12(cap12));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  // read data only stand in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, exp, o_rdata);
  endtask
  // write, then read on the very next edge with no idle cycle between
  task automatic wrrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                      input string nm);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(nm, exp, o_rdata);
  endtask
  task automatic rst(input logic deep);
    @(posedge i_clk);
    i_rst <= 1'b1;
    i_rst_deep_stby <= deep;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    i_rst_deep_stby <= 1'b0;
    #1;
  endtask
  function automatic logic [1:0] cap_exp(input logic [2:0] c);
    case (c)
      3'h0, 3'h1: return PIN0_PAT;
      3'h2: return PIN1_PAT;
      3'h4: return {SYNC_PAT[3], SYNC_PAT[2]};
      3'h5: return {SYNC_PAT[7], SYNC_PAT[6]};
      default: return 2'h0;
    endcase
  endfunction
  task automatic conclude;
    if (err_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    conclude();
  end
  initial begin
    logic [1:0] cd;
    rst(1'b0);
    chk("oe0_n", 32'h0000_0FFF, {20'h0, oe0_n});
    chk("oe1_n", 32'h0000_0FFF, {20'h0, oe1_n});
    chk("pad0", 32'h0000_0000, {20'h0, pad0});
    rdc(U0_ROUTE_ADDR, 32'h0000_0000, "unit0");
    rdc(U1_ROUTE_ADDR, 32'h0000_0000, "unit1");
    for (int c = 0; c < 4; c++) begin
      cd = c[1:0];
      wr(U0_ROUTE_ADDR, {20'h0, {6{cd}}});
      wr(U1_ROUTE_ADDR, {20'h0, {6{cd}}});
      chk("oe0_n", (cd == 2'h1) ? 32'h0 : 32'hFFF, {20'h0, oe0_n});
      chk("oe1_n", (cd == 2'h2) ? 32'h0 : 32'hFFF, {20'h0, oe1_n});
      chk("pad0", (cd == 2'h1) ? {20'h0, WAVE_PAT} : 32'h0, {20'h0, pad0});
      chk("pad1", (cd == 2'h2) ? {20'h0, WAVE_PAT} : 32'h0, {20'h0, pad1});
      rdc(U0_ROUTE_ADDR, {20'h0, {6{cd}}}, "unit0");
    end
    wr(U1_ROUTE_ADDR, 32'hFFFF_1FFF);
    rdc(U1_ROUTE_ADDR, 32'hFFFF_1FFF, "unit1");
    rdc(8'h08, 32'h0000_0000, "unmapped");
    wrrd(U0_ROUTE_ADDR, 32'h0000_06A5, 32'h0000_06A5, "unit0 b2b");
    wrrd(U1_ROUTE_ADDR, 32'h9765_0A5A, 32'h9765_0A5A, "unit1 b2b");
    // trip mode on, all unit 1 outputs on option 0
    wr(U1_ROUTE_ADDR, 32'h0000_1555);
    @(posedge i_clk);
    trip_set <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk("trip pad0", {26'h0, gpio_set}, {26'h0, pad0[11:6]});
    wr(U1_ROUTE_ADDR, 32'h0000_0555);
    repeat (2) @(posedge i_clk);
    #1;
    chk("no trip pad0", {26'h0, WAVE_PAT[11:6]}, {26'h0, pad0[11:6]});
    @(posedge i_clk);
    trip_set <= 1'b0;
    for (int c = 0; c < 8; c++) begin
      wr(U1_ROUTE_ADDR, {c[2:0], c[2:0], 26'h0});
      repeat (4) @(posedge i_clk);
      #1;
      chk("captures", {30'h0, cap_exp(c[2:0])}, {30'h0, cap13, cap12});
    end
    wr(U0_ROUTE_ADDR, 32'h0000_0249);
    rst(1'b1);
    rdc(U0_ROUTE_ADDR, 32'h0000_0249, "unit0 kept");
    rdc(U1_ROUTE_ADDR, 32'h0000_0000, "unit1");
    rst(1'b0);
    rdc(U0_ROUTE_ADDR, 32'h0000_0000, "unit0");
    conclude();
  end
endmodule // tb
